// ---- core/rsb_pkg.sv ----
// Purpose: Shared constants, state type and register map of the RGB serial
//          link bridge.
// Assumes: 200 MHz core clock; the link clock is sampled, not used as clock.
// Notes:   Word layout, register offsets and timing counts live here only.
//
// Summary of operation
// - Transmit mode serializes each pixel word over one, two or three lanes.
// - Receive mode recovers pixel words and control bits from up to three lanes.
// - Bits per lane per pixel are thirty, fifteen or ten for one to three lanes.
// - Parallel side has 24 colour bits, low syncs and high pixel-valid.
// - Two auxiliary bits travel from transmitter inputs to receiver outputs.
// - Shutdown low keeps the whole link and parallel side inactive.
// - With shutdown high, standby moves to active once a running clock appears.
// - Transmitter adds odd parity over colour, syncs and pixel-valid.
// - Receiver checks odd parity per word and raises the parity error output.
// - On a parity failure the last good pixel is repeated on the outputs.
// - Receive mode reports the frame mixing input in status; pixels pass unchanged.
// - Two timing methods: pixel-referenced with gaps, bit clock without overhead.
// - Parallel and lane order reverse between transmit and receive.
// - Two pinout selects mirror parallel bit order and lane order.

package rsb_pkg;

  // Clock and link timing.
  localparam int CLK_PERIOD_NS = 5;
  localparam int BIT_HALF_NS   = 40;
  localparam int BIT_HALF_CYC  = (BIT_HALF_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 BIT_HALF_NS / CLK_PERIOD_NS;
  localparam int GAP_MIN_NS    = 120;
  localparam int GAP_MIN_CYC   = (GAP_MIN_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam int LOSS_NS       = 1000;
  localparam int LOSS_CYC      = (LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] TX_GAP_HALVES = 3'h4;

  // Serial word layout.
  localparam int WORD_W  = 30;
  localparam int RGB_LSB = 0;
  localparam int HS_POS  = 24;
  localparam int VS_POS  = 25;
  localparam int PV_POS  = 26;
  localparam int AUX_LSB = 27;
  localparam int PAR_POS = 29;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_EN   = 8'h0C;
  localparam logic [7:0] REG_IRQ_CLR  = 8'h10;
  localparam logic [7:0] REG_ERR_CNT  = 8'h14;

  // Interrupt bit positions and reset values.
  localparam int IRQ_W    = 3;
  localparam int IRQ_PAR  = 0;
  localparam int IRQ_UP   = 1;
  localparam int IRQ_DOWN = 2;
  localparam logic             CTRL_EN_RST = 1'b1;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST  = 3'h0;

  // Idle values of the parallel outputs.
  localparam logic [23:0] RGB_IDLE = 24'h00_0000;
  localparam logic        SYNC_IDLE = 1'b1;

  // Power states.
  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_STBY = 3'b010,
    ST_ACT  = 3'b100
  } rsb_pwr_e;

endpackage : rsb_pkg

// ---- core/rsb_bridge.sv ----
// Purpose: Serializer or deserializer between a parallel RGB port and up to
//          three serial lanes plus a lane clock, with a Wishbone slave.
// Assumes: All pins except reset and the Wishbone bus are asynchronous to clk_in and pass two flip-flops.
// Notes:   The lane clock is sampled by clk_in; bit period is 80 ns.
`timescale 1ns/1ps
`default_nettype none

module rsb_bridge
  import rsb_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic [3:0]  wb_sel_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  output logic             irq_out,
  input  wire logic        shutdown_n_in,
  input  wire logic        tx_mode_in,
  input  wire logic [1:0]  lane_sel_in,
  input  wire logic [1:0]  pinout_sel_in,
  input  wire logic        frame_mix_in,
  input  wire logic        bit_clk_mode_in,
  input  wire logic        pclk_in,
  input  wire logic        link_clk_in,
  input  wire logic [2:0]  link_data_in,
  input  wire logic [23:0] rgb_in,
  input  wire logic        hsync_n_in,
  input  wire logic        vsync_n_in,
  input  wire logic        pixel_valid_in,
  input  wire logic [1:0]  aux_in,
  output logic             link_clk_out,
  output logic      [2:0]  link_data_out,
  output logic      [23:0] rgb_out,
  output logic             hsync_n_out,
  output logic             vsync_n_out,
  output logic             pixel_valid_out,
  output logic      [1:0]  aux_out,
  output logic             parity_error_out
);

  // Lane count from the lane select code; zero means one lane.
  function automatic logic [1:0] lanes_of(input logic [1:0] sel);
    lanes_of = (sel == 2'h0) ? 2'h1 : sel;
  endfunction : lanes_of

  // Last slot index of a word for a lane count.
  function automatic logic [4:0] last_slot(input logic [1:0] n);
    unique case (n)
      2'h2:    last_slot = 5'h0E;
      2'h3:    last_slot = 5'h09;
      default: last_slot = 5'h1D;
    endcase
  endfunction : last_slot

  // Drops the bits already sent on the active lanes.
  function automatic logic [29:0] shr(input logic [29:0] x,
                                      input logic [1:0] n);
    unique case (n)
      2'h2:    shr = {2'h0, x[29:2]};
      2'h3:    shr = {3'h0, x[29:3]};
      default: shr = {1'h0, x[29:1]};
    endcase
  endfunction : shr

  // Inserts the bits of the active lanes at the top of the word.
  function automatic logic [29:0] ins(input logic [29:0] x,
                                      input logic [2:0] d,
                                      input logic [1:0] n);
    unique case (n)
      2'h2:    ins = {d[1:0], x[29:2]};
      2'h3:    ins = {d, x[29:3]};
      default: ins = {d[0], x[29:1]};
    endcase
  endfunction : ins

  // Mirrors a parallel colour bus.
  function automatic logic [23:0] rev24(input logic [23:0] x);
    for (int i = 0; i < 24; i++) begin
      rev24[i] = x[23-i];
    end
  endfunction : rev24

  // Two-stage synchroniser for every pin input except reset and the Wishbone bus.
  localparam int SW = 42;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic          shut_n_s, tx_s, fmix_s, bitm_s, pclk_s, lclk_s;
  logic          hs_s, vs_s, pv_s;
  logic [1:0]    lsel_s, psel_s, aux_s;
  logic [2:0]    ldat_s;
  logic [23:0]   rgb_s;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {shutdown_n_in, tx_mode_in, lane_sel_in, pinout_sel_in,
               frame_mix_in, bit_clk_mode_in, pclk_in, link_clk_in,
               link_data_in, rgb_in, hsync_n_in, vsync_n_in,
               pixel_valid_in, aux_in};
      s2_q <= s1_q;
    end
  end
  assign {shut_n_s, tx_s, lsel_s, psel_s, fmix_s, bitm_s, pclk_s, lclk_s,
          ldat_s, rgb_s, hs_s, vs_s, pv_s, aux_s} = s2_q;

  // Clock edge detection and mode decoding.
  logic       pclk_d_q, lclk_d_q;
  logic [1:0] nl;
  logic [4:0] slot_end;
  logic       pclk_rise, lclk_rise, act_edge, par_rev, lane_rev;
  assign pclk_rise = pclk_s & ~pclk_d_q;
  assign lclk_rise = lclk_s & ~lclk_d_q;
  assign act_edge  = tx_s ? pclk_rise : lclk_rise;
  assign nl        = lanes_of(lsel_s);
  assign slot_end  = last_slot(nl);
  assign par_rev   = psel_s[0] ^ ~tx_s;
  assign lane_rev  = psel_s[1] ^ ~tx_s;

  // Power state machine driven by shutdown and clock activity.
  rsb_pwr_e st_q, st_d;
  logic     ctrl_en_q;
  logic [8:0] idle_q;
  logic     loss, active, tx_on, rx_on;
  assign loss   = (idle_q >= 9'(LOSS_CYC));
  assign active = (st_q == ST_ACT);
  assign tx_on  = active & tx_s;
  assign rx_on  = active & ~tx_s;
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_OFF:  st_d = ST_STBY;
      ST_STBY: if (act_edge && ctrl_en_q) st_d = ST_ACT;
      ST_ACT:  if (loss || !ctrl_en_q) st_d = ST_STBY;
      default: st_d = ST_OFF;
    endcase
    if (!shut_n_s) st_d = ST_OFF;
  end
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_q     <= ST_OFF;
      idle_q   <= '0;
      pclk_d_q <= 1'b0;
      lclk_d_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      idle_q   <= act_edge ? 9'h000 : (loss ? idle_q : idle_q + 9'h001);
      pclk_d_q <= pclk_s;
      lclk_d_q <= lclk_s;
    end
  end

  // Transmit word assembly with odd parity.
  logic [23:0] tx_rgb;
  logic [26:0] tx_body;
  logic [29:0] tx_word_q, tx_sh_q;
  assign tx_rgb  = par_rev ? rev24(rgb_s) : rgb_s;
  assign tx_body = {pv_s, vs_s, hs_s, tx_rgb};
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      tx_word_q <= '0;
    end else if (tx_s && pclk_rise && st_d == ST_ACT) begin
      // The waking edge also latches, so the first load is a real pixel.
      tx_word_q <= {~^tx_body, aux_s, tx_body};
    end
  end

  // Transmit engine: half-bit divider, lane clock and shifter.
  logic [7:0] tx_half_q;
  logic [4:0] tx_slot_q;
  logic [2:0] tx_gap_q;
  logic       tx_run_q, lclk_q, tx_tick, tx_fall, tx_load;
  assign tx_tick = (tx_half_q == 8'(BIT_HALF_CYC - 1));
  assign tx_fall = tx_tick & tx_run_q & lclk_q;
  assign tx_load = tx_on & tx_tick &
                   ((!tx_run_q && tx_gap_q == 3'h0) ||
                    (tx_fall && tx_slot_q == slot_end && bitm_s));
  always_ff @(posedge clk_in) begin
    if (!nrst_in || !tx_on) begin
      tx_half_q <= '0;
      tx_slot_q <= '0;
      tx_gap_q  <= '0;
      tx_run_q  <= 1'b0;
      lclk_q    <= 1'b0;
      tx_sh_q   <= '0;
    end else if (tx_tick) begin
      tx_half_q <= '0;
      if (tx_load) begin
        tx_sh_q   <= tx_word_q;
        tx_slot_q <= '0;
        tx_run_q  <= 1'b1;
        lclk_q    <= 1'b0;
      end else if (tx_gap_q != 3'h0) begin
        tx_gap_q <= tx_gap_q - 3'h1;
      end else if (!lclk_q) begin
        lclk_q <= 1'b1;
      end else begin
        lclk_q <= 1'b0;
        if (tx_slot_q == slot_end) begin
          tx_run_q <= 1'b0;
          tx_gap_q <= TX_GAP_HALVES;
        end else begin
          tx_sh_q   <= shr(tx_sh_q, nl);
          tx_slot_q <= tx_slot_q + 5'h01;
        end
      end
    end else begin
      tx_half_q <= tx_half_q + 8'h01;
    end
  end

  // Active lanes of the shifter, mirrored as the pinout asks.
  logic [2:0] lane_mask, lane_bits, lane_pin, rx_lanes;
  assign lane_mask = (nl == 2'h3) ? 3'h7 : ((nl == 2'h2) ? 3'h3 : 3'h1);
  assign lane_bits = tx_run_q ? (tx_sh_q[2:0] & lane_mask) : 3'h0;
  assign lane_pin  = lane_rev ? {lane_bits[0], lane_bits[1], lane_bits[2]}
                              : lane_bits;
  assign rx_lanes  = lane_rev ? {ldat_s[0], ldat_s[1], ldat_s[2]} : ldat_s;

  // Receive deserializer with gap framing in pixel-referenced mode.
  logic [29:0] rx_sh_q, rx_word;
  logic [4:0]  rx_cnt_q;
  logic        rx_done, par_ok, rx_gap;
  assign rx_word = ins(rx_sh_q, rx_lanes, nl);
  assign rx_done = rx_on & lclk_rise & (rx_cnt_q == slot_end);
  assign par_ok  = ^{rx_word[PAR_POS], rx_word[PV_POS:0]};
  assign rx_gap  = ~bitm_s & (idle_q >= 9'(GAP_MIN_CYC));
  always_ff @(posedge clk_in) begin
    if (!nrst_in || !rx_on) begin
      rx_sh_q  <= '0;
      rx_cnt_q <= '0;
    end else if (lclk_rise) begin
      rx_sh_q  <= rx_word;
      rx_cnt_q <= (rx_cnt_q == slot_end) ? 5'h00 : rx_cnt_q + 5'h01;
    end else if (rx_gap) begin
      rx_cnt_q <= '0;
    end
  end

  // Parallel outputs; a failed word leaves the last good pixel standing.
  logic [23:0] rgb_q;
  logic        hs_q, vs_q, pv_q, perr_q;
  logic [1:0]  aux_q;
  logic [15:0] err_cnt_q;
  always_ff @(posedge clk_in) begin
    if (!nrst_in || !rx_on) begin
      rgb_q  <= RGB_IDLE;
      hs_q   <= SYNC_IDLE;
      vs_q   <= SYNC_IDLE;
      pv_q   <= 1'b0;
      aux_q  <= 2'h0;
      perr_q <= 1'b0;
    end else if (rx_done) begin
      perr_q <= ~par_ok;
      if (par_ok) begin
        // Frame mixing passes pixels unchanged.
        rgb_q <= par_rev ? rev24(rx_word[23:RGB_LSB])
                         : rx_word[23:RGB_LSB];
        hs_q  <= rx_word[HS_POS];
        vs_q  <= rx_word[VS_POS];
        pv_q  <= rx_word[PV_POS];
        aux_q <= rx_word[AUX_LSB+1:AUX_LSB];
      end
    end
  end

  // Wishbone slave: one wait state, writes land on the acknowledged edge.
  logic        req, wr_fire, ack_q;
  logic [31:0] rd_d, rd_q;
  logic [IRQ_W-1:0] irq_st_q, irq_st_d, irq_en_q, irq_ev, irq_clr;
  logic        irq_q, lane_clk_q;
  logic [2:0]  lane_q;
  assign req     = wb_cyc_in & wb_stb_in;
  assign wr_fire = req & wb_we_in & ack_q & wb_sel_in[0];
  assign irq_clr = (wr_fire && wb_adr_in == REG_IRQ_CLR) ?
                   wb_dat_in[IRQ_W-1:0] : '0;
  assign irq_ev  = {active & (st_d != ST_ACT), ~active & (st_d == ST_ACT),
                    rx_done & ~par_ok};
  assign irq_st_d = (irq_st_q & ~irq_clr) | irq_ev;         // set wins
  always_comb begin
    unique case (wb_adr_in)
      REG_CTRL:     rd_d = {31'h0000_0000, ctrl_en_q};
      REG_STATUS:   rd_d = {23'h00_0000, perr_q, fmix_s, bitm_s, tx_s,
                            nl, st_q};
      REG_IRQ_STAT: rd_d = {29'h0000_0000, irq_st_q};
      REG_IRQ_EN:   rd_d = {29'h0000_0000, irq_en_q};
      REG_ERR_CNT:  rd_d = {16'h0000, err_cnt_q};
      default:      rd_d = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ack_q      <= 1'b0;
      rd_q       <= '0;
      ctrl_en_q  <= CTRL_EN_RST;
      irq_en_q   <= IRQ_EN_RST;
      irq_st_q   <= '0;
      irq_q      <= 1'b0;
      err_cnt_q  <= '0;
      lane_q     <= '0;
      lane_clk_q <= 1'b0;
    end else begin
      ack_q     <= req & ~ack_q;
      rd_q      <= (req && !ack_q) ? rd_d : rd_q;
      if (wr_fire && wb_adr_in == REG_CTRL) ctrl_en_q <= wb_dat_in[0];
      if (wr_fire && wb_adr_in == REG_IRQ_EN)
        irq_en_q <= wb_dat_in[IRQ_W-1:0];
      irq_st_q   <= irq_st_d;
      irq_q      <= |(irq_st_d & irq_en_q);
      err_cnt_q  <= err_cnt_q + {15'h0000, rx_done & ~par_ok};
      lane_q     <= tx_on ? lane_pin : 3'h0;
      lane_clk_q <= tx_on & lclk_q;
    end
  end

  assign wb_ack_out       = ack_q;
  assign wb_dat_out       = rd_q;
  assign irq_out          = irq_q;
  assign link_clk_out     = lane_clk_q;
  assign link_data_out    = lane_q;
  assign rgb_out          = rgb_q;
  assign hsync_n_out      = hs_q;
  assign vsync_n_out      = vs_q;
  assign pixel_valid_out  = pv_q;
  assign aux_out          = aux_q;
  assign parity_error_out = perr_q;

  // Checks on the behaviour above.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  AST_SHUTDOWN: assert property (!shut_n_s |=> st_q == ST_OFF ##1 !link_clk_out)
    else $error("shutdown did not stop the link");
  AST_WAKE: assert property (st_q == ST_STBY && shut_n_s && act_edge && ctrl_en_q |=> active)
    else $error("standby missed a running clock");
  AST_PAR_GEN: assert property (tx_load |=> ^{tx_sh_q[PAR_POS], tx_sh_q[PV_POS:0]})
    else $error("transmit word parity is not odd");
  AST_PAR_ERR: assert property (rx_done && !par_ok |=> parity_error_out)
    else $error("parity error not flagged");
  AST_HOLD_LAST: assert property (rx_done && !par_ok |=> $stable(rgb_out) && $stable(aux_out))
    else $error("corrupt word reached the outputs");
  AST_BIT_TIME: assert property ($rose(link_clk_out) |=> (link_clk_out || !$past(tx_on)) [*7] ##1 !link_clk_out)
    else $error("lane clock high phase has the wrong length");
  AST_PASS: assert property (rx_done && par_ok && !par_rev |=> rgb_out == $past(rx_word[23:0]) && pixel_valid_out == $past(rx_word[PV_POS]))
    else $error("good word not passed to outputs");
  AST_IRQ: assert property (rx_done && !par_ok && irq_en_q[IRQ_PAR] |=> ##[0:1] irq_out)
    else $error("enabled parity event raised no interrupt");
  AST_ACK: assert property (req && !ack_q |=> wb_ack_out ##1 !wb_ack_out)
    else $error("bus answer not a single cycle");

endmodule : rsb_bridge

`default_nettype wire

// ---- sim/rsb_link_peer.sv ----
// Purpose: Far-end lane model that captures sent words and sends words in.
// Assumes: Lane bit period is 80 ns; bit k of a word is slot*lanes+lane.
// Notes:   The lane clock stands low between words; idle lanes toggle.
`timescale 1ns/1ps
`default_nettype none

module rsb_link_peer (
  input  wire logic        clk_in,
  input  wire logic [1:0]  lanes_in,
  input  wire logic        lclk_in,
  input  wire logic [2:0]  ldat_in,
  output logic             lclk_out,
  output logic      [2:0]  ldat_out,
  output logic      [29:0] cap_out,
  output logic             cap_stb_out,
  output logic             tgl_out
);
  int          nl;
  int          slot_q = 0;
  int          idle_q = 0;
  logic        prev_q = 1'b0;
  logic [29:0] acc_q;

  // Codes 0 and 1 both select one lane.
  assign nl = (lanes_in < 2'h2) ? 1 : int'(lanes_in);

  // Takes one bit per lane at each lane clock rise; a long gap restarts.
  always @(posedge clk_in) begin
    prev_q <= lclk_in;
    cap_stb_out <= 1'b0;
    idle_q <= idle_q + 1;
    if (lclk_in && !prev_q) begin
      idle_q <= 0;
      for (int l = 0; l < nl; l++)
        acc_q[slot_q * nl + l] = ldat_in[l];
      if (slot_q == 30 / nl - 1) begin
        cap_out <= acc_q;
        cap_stb_out <= 1'b1;
        slot_q <= 0;
      end else begin
        slot_q <= slot_q + 1;
      end
    end else if (idle_q > 30) begin
      slot_q <= 0;
    end
  end

  // The lanes start quiet.
  initial begin
    lclk_out = 1'b0;
    ldat_out = 3'h0;
    tgl_out = 1'b0;
  end

  // Sends a word slot by slot, data set while the lane clock is low.
  task automatic send_word(input logic [29:0] w);
    #3;
    for (int s = 0; s < 30 / nl; s++) begin
      for (int l = 0; l < 3; l++)
        ldat_out[l] = (l < nl) ? w[s * nl + l] : ~ldat_out[l];
      #40 lclk_out = 1'b1;
      #40 lclk_out = 1'b0;
    end
    ldat_out = ~ldat_out;
    tgl_out = ~tgl_out;
    #300;
  endtask : send_word
endmodule : rsb_link_peer
`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: Self-checking bench of the RGB serial link bridge.
// Assumes: The peer model faces the lanes; a Wishbone classic master.
// Notes:   Stream results are queued by the driver and checked by monitors.
`timescale 1ns/1ps
`default_nettype none

module tb
  import rsb_pkg::*;
;
  logic        clk_in, nrst_in, cyc, stb, we, sd_n, txm, fmix, pclk, prun;
  logic        hsync_n, vsync_n, pvalid, bitm;
  logic [1:0]  lsel, psel, aux;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [23:0] rgb;
  logic [31:0] dat, wb_q, lfsr_q, e0;
  logic [29:0] last_tx, g;
  logic [29:0] tx_q[$];
  logic [29:0] rx_q[$];
  int          num_errors, n_compared;
  wire logic        ack, irq, lclk_o, lclk_i, hsync_o, vsync_o, pvalid_o;
  wire logic        perr, cs, tg;
  wire logic [1:0]  aux_o;
  wire logic [2:0]  ldat_o, ldat_i;
  wire logic [23:0] rgb_o;
  wire logic [29:0] cap;
  wire logic [31:0] wb_d;

  rsb_bridge i_rsb_bridge (
    .clk_in(clk_in), .nrst_in(nrst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(dat), .wb_sel_in(sel),
    .wb_dat_out(wb_d), .wb_ack_out(ack), .irq_out(irq),
    .shutdown_n_in(sd_n), .tx_mode_in(txm), .lane_sel_in(lsel),
    .pinout_sel_in(psel), .frame_mix_in(fmix), .bit_clk_mode_in(bitm),
    .pclk_in(pclk), .link_clk_in(lclk_i), .link_data_in(ldat_i),
    .rgb_in(rgb), .hsync_n_in(hsync_n), .vsync_n_in(vsync_n),
    .pixel_valid_in(pvalid), .aux_in(aux), .link_clk_out(lclk_o),
    .link_data_out(ldat_o), .rgb_out(rgb_o), .hsync_n_out(hsync_o),
    .vsync_n_out(vsync_o), .pixel_valid_out(pvalid_o), .aux_out(aux_o),
    .parity_error_out(perr)
  );

  rsb_link_peer i_rsb_link_peer (
    .clk_in(clk_in), .lanes_in(lsel), .lclk_in(lclk_o), .ldat_in(ldat_o),
    .lclk_out(lclk_i), .ldat_out(ldat_i), .cap_out(cap), .cap_stb_out(cs),
    .tgl_out(tg)
  );

  // Core clock at 200 MHz.
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Pixel clock toggles every 50 core cycles while it runs.
  always begin
    repeat (50) @(posedge clk_in);
    if (prun) pclk <= ~pclk;
  end

  // A new captured word is checked against the oldest queued pixel.
  always @(posedge clk_in) begin
    if (cs === 1'b1 && cap !== last_tx) begin
      if (tx_q.size() > 0) check({2'b00, cap}, {2'b00, tx_q.pop_front()});
      last_tx = cap;
    end
  end

  // Receive outputs are checked shortly after each word ends.
  always @(tg) begin
    repeat (8) @(posedge clk_in);
    if (rx_q.size() > 0)
      check({2'b00, perr, aux_o, pvalid_o, vsync_o, hsync_o, rgb_o},
            {2'b00, rx_q.pop_front()});
  end

  // Mirrors the colour bits, as a mirrored pinout does.
  function automatic logic [23:0] rev_rgb(input logic [23:0] x);
    for (int i = 0; i < 24; i++)
      rev_rgb[i] = x[23 - i];
  endfunction : rev_rgb

  // Expected receive outputs; receive mirrors colour unless psel bit 0 is set.
  function automatic logic [29:0] rx_exp(input logic [29:0] w,
                                         input logic pe);
    return {pe, w[28:24], psel[0] ? w[23:0] : rev_rgb(w[23:0])};
  endfunction : rx_exp

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    for (int i = 0; i < 32; i++)
      s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction : lfsr_next

  // Builds a random word with good or broken odd parity.
  function automatic logic [29:0] mk_word(input logic ok);
    logic [26:0] p;
    lfsr_q = lfsr_next(lfsr_q);
    p = lfsr_q[26:0];
    return {(^p) ^ ok, lfsr_q[28:27], p};
  endfunction : mk_word

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // One classic cycle, held until ack is sampled high.
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      $display("[ERR] %0t bus answer missing", $time);
      end_sim();
    end
    wb_q = wb_d;
    {cyc, stb} <= 2'b00;
    @(posedge clk_in);
  endtask : wb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e);
    wb(a, 1'b0, 32'h0000_0000);
    check(wb_q & m, e);
  endtask : rd_chk

  task automatic idle_chk();
    check({ldat_o, rgb_o, hsync_o, vsync_o, pvalid_o, aux_o}, 32'h0000_0018);
    check({31'h0, lclk_o | perr}, 32'h0000_0000);
  endtask : idle_chk

  // Drives a pixel, queues its word and holds it for 1200 core cycles.
  task automatic send_px();
    logic [29:0] w;
    w = mk_word(1'b1);
    {aux, pvalid, vsync_n, hsync_n, rgb} <= w[28:0];
    tx_q.push_back(psel[0] ? {w[29:24], rev_rgb(w[23:0])} : w);
    repeat (1200) @(posedge clk_in);
    check(32'(tx_q.size()), 32'h0000_0000);
  endtask : send_px

  task automatic rx_send(input logic [29:0] w, input logic [29:0] e);
    rx_q.push_back(e);
    i_rsb_link_peer.send_word(w);
  endtask : rx_send

  // Main sequence: shutdown, transmit per lane code, receive, shutdown.
  initial begin
    {nrst_in, cyc, stb, we, sd_n, txm, fmix, pclk, prun} = '0;
    {hsync_n, vsync_n, pvalid, bitm, lsel, psel, aux, rgb} = '0;
    {sel, adr, dat} = '0;
    lfsr_q = 32'h0000_062C;
    last_tx = 30'h0000_0000;
    num_errors = 0;
    n_compared = 0;
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    sel <= 4'hF;
    repeat (4) @(posedge clk_in);
    rd_chk(REG_STATUS, 32'h0000_0007, 32'h0000_0001);
    rd_chk(REG_CTRL, 32'h0000_0001, 32'h0000_0001);
    rd_chk(REG_IRQ_EN, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    idle_chk();
    sd_n <= 1'b1;
    txm <= 1'b1;
    wb(REG_IRQ_EN, 1'b1, 32'h0000_0007);
    rd_chk(REG_STATUS, 32'h0000_0007, 32'h0000_0002);
    prun <= 1'b1;
    repeat (200) @(posedge clk_in);
    rd_chk(REG_STATUS, 32'h0000_0007, 32'h0000_0004);
    rd_chk(REG_IRQ_STAT, 32'h0000_0007, 32'h0000_0002);
    check({31'h0, irq}, 32'h0000_0001);
    wb(REG_IRQ_CLR, 1'b1, 32'h0000_0007);
    rd_chk(REG_IRQ_STAT, 32'h0000_0007, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    wb(REG_CTRL, 1'b1, 32'h0000_0000);
    rd_chk(REG_STATUS, 32'h0000_0007, 32'h0000_0002);
    rd_chk(REG_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
    wb(REG_CTRL, 1'b1, 32'h0000_0001);
    for (int n = 0; n < 4; n++) begin
      lsel <= 2'(n);
      psel <= {1'b0, 1'(n % 2)};
      repeat (1200) @(posedge clk_in);
      bitm <= (n == 3);
      send_px();
      send_px();
    end
    prun <= 1'b0;
    txm <= 1'b0;
    bitm <= 1'b0;
    wb(REG_IRQ_EN, 1'b1, 32'h0000_0001);
    for (int n = 1; n < 4; n++) begin
      lsel <= 2'(n);
      fmix <= (n == 2);
      psel <= {1'b1, (n != 2)};
      i_rsb_link_peer.send_word(mk_word(1'b1));
      wb(REG_IRQ_CLR, 1'b1, 32'h0000_0007);
      wb(REG_ERR_CNT, 1'b0, 32'h0000_0000);
      e0 = wb_q;
      g = mk_word(1'b1);
      rx_send(g, rx_exp(g, 1'b0));
      rx_send(mk_word(1'b0), rx_exp(g, 1'b1));
      g = mk_word(1'b1);
      rx_send(g, rx_exp(g, 1'b0));
      rd_chk(REG_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
      check({31'h0, irq}, 32'h0000_0001);
      rd_chk(REG_ERR_CNT, 32'h0000_FFFF, (e0 + 32'h1) & 32'h0000_FFFF);
      wb(REG_IRQ_CLR, 1'b1, 32'h0000_0001);
      check({31'h0, irq}, 32'h0000_0000);
    end
    sd_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    rd_chk(REG_STATUS, 32'h0000_0007, 32'h0000_0001);
    idle_chk();
    check(32'(tx_q.size() + rx_q.size()), 32'h0000_0000);
    end_sim();
  end
endmodule : tb
`default_nettype wire
